// [rtl/lineif_control_status_regs.sv]
// Host register bank of the quad line interface: main and expanded maps
`timescale 1ns/1ps
`default_nettype none
`include "lineif_params.svh"

module lineif_control_status_regs
    import lineif_pkg::*;
#(
    parameter int    CHANNELS      = 4,
    parameter byte_t REVISION_CODE = 8'hA5   // Arbitrary value
) (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // Host register port
    input  wire logic  reg_wr,
    input  wire logic  reg_rd,
    input  wire addr_t reg_addr,
    input  wire byte_t reg_wdata,
    output var  byte_t reg_rdata,
    output var  logic  reg_rvalid,
    // Line status inputs, asynchronous
    input  wire chan_t signal_absent_in,
    input  wire chan_t driver_fault_in,
    input  wire chan_t inband_detect_in,
    // Channel controls
    output var  chan_t analog_loopback_en,
    output var  chan_t far_end_loopback_en,
    output var  chan_t all_ones_tx_en,
    // In-band loopback configuration
    output var  logic       inband_cfg_bit5,
    output var  logic       inband_cfg_bit4,
    output var  logic [1:0] inband_cfg_field_a,
    output var  logic [1:0] inband_cfg_field_b,
    output var  byte_t      inband_code_byte_a,
    output var  byte_t      inband_code_byte_b,
    // Event levels
    output var  logic  signal_absent_irq,
    output var  logic  inband_irq
);

    if (CHANNELS != 4) begin : g_chk
        $error("lineif_control_status_regs supports exactly four channels");
    end

    // Stored registers
    byte_t analog_lb_r;
    byte_t far_end_lb_r;
    byte_t all_ones_r;
    byte_t absent_mask_r;
    byte_t page_r;
    chan_t absent_flag_r;
    chan_t absent_flag_nxt;
    chan_t inb_flag_r;
    chan_t inb_flag_nxt;
    byte_t ext_r [0:15];
    byte_t rdata_r;
    logic  rvalid_r;
    logic  absent_irq_r;
    logic  inb_irq_r;

    // Input synchronisers and change detectors
    chan_t absent_s1_r;
    chan_t absent_s2_r;
    chan_t absent_prev_r;
    chan_t fault_s1_r;
    chan_t fault_s2_r;
    chan_t inb_s1_r;
    chan_t inb_s2_r;
    chan_t inb_prev_r;

    // Decode
    wire logic  ext_sel     = (page_r != `RST_PAGE);
    wire logic  page_hit    = (reg_addr == `OFS_PAGE_POINTER);
    wire logic  main_acc    = !ext_sel && !page_hit;
    wire logic  ext_acc     = ext_sel && !page_hit && (reg_addr[4] == 1'b0);
    wire logic [3:0] ext_idx = reg_addr[3:0];
    wire logic  ext_wr_ok   = (ext_idx != `OFS_EXT_INB_STATUS) && (ext_idx != `OFS_EXT_INB_FLAG);
    wire logic  wr_page     = reg_wr && page_hit;
    wire logic  wr_alb      = reg_wr && main_acc && (reg_addr == `OFS_ANALOG_LB);
    wire logic  wr_rlb      = reg_wr && main_acc && (reg_addr == `OFS_FAR_END_LB);
    wire logic  wr_tao      = reg_wr && main_acc && (reg_addr == `OFS_ALL_ONES_TX);
    wire logic  wr_mask     = reg_wr && main_acc && (reg_addr == `OFS_ABSENT_MASK);
    wire logic  wr_ext      = reg_wr && ext_acc && ext_wr_ok;
    wire logic  rd_absent   = reg_rd && main_acc && (reg_addr == `OFS_ABSENT_STATUS);
    wire logic  rd_inb      = reg_rd && ext_acc && (ext_idx == `OFS_EXT_INB_STATUS);

    // Event detection: set wins over read clear
    wire chan_t absent_set  = absent_mask_r[3:0] & (absent_s2_r ^ absent_prev_r);
    wire chan_t inb_set     = ext_r[`OFS_EXT_INB_MASK][3:0] & (inb_s2_r ^ inb_prev_r);
    assign absent_flag_nxt  = (absent_flag_r & ~(rd_absent ? 4'hF : 4'h0)) | absent_set;
    assign inb_flag_nxt     = (inb_flag_r & ~(rd_inb ? 4'hF : 4'h0)) | inb_set;

    function automatic byte_t pad4(input chan_t v);
        pad4 = {4'h0, v};
    endfunction

    // Read multiplexer
    byte_t main_rd;
    byte_t ext_rd;
    always_comb begin
        case (reg_addr)
            `OFS_REVISION:      main_rd = REVISION_CODE;
            `OFS_ANALOG_LB:     main_rd = analog_lb_r;
            `OFS_FAR_END_LB:    main_rd = far_end_lb_r;
            `OFS_ALL_ONES_TX:   main_rd = all_ones_r;
            `OFS_ABSENT_STATUS: main_rd = pad4(absent_s2_r);
            `OFS_FAULT_STATUS:  main_rd = pad4(fault_s2_r);
            `OFS_ABSENT_MASK:   main_rd = absent_mask_r;
            `OFS_ABSENT_FLAG:   main_rd = pad4(absent_flag_r);
            default:            main_rd = `RST_BYTE;
        endcase
    end

    always_comb begin
        case (ext_idx)
            `OFS_EXT_INB_STATUS: ext_rd = pad4(inb_s2_r);
            `OFS_EXT_INB_FLAG:   ext_rd = pad4(inb_flag_r);
            default:             ext_rd = ext_r[ext_idx];
        endcase
    end

    wire byte_t rd_mux = page_hit ? page_r : (ext_sel ? (ext_acc ? ext_rd : `RST_BYTE) : main_rd);

    // Synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            absent_s1_r   <= `RST_CHAN;
            absent_s2_r   <= `RST_CHAN;
            absent_prev_r <= `RST_CHAN;
            fault_s1_r    <= `RST_CHAN;
            fault_s2_r    <= `RST_CHAN;
            inb_s1_r      <= `RST_CHAN;
            inb_s2_r      <= `RST_CHAN;
            inb_prev_r    <= `RST_CHAN;
        end else begin
            absent_s1_r   <= signal_absent_in;
            absent_s2_r   <= absent_s1_r;
            absent_prev_r <= absent_s2_r;
            fault_s1_r    <= driver_fault_in;
            fault_s2_r    <= fault_s1_r;
            inb_s1_r      <= inband_detect_in;
            inb_s2_r      <= inb_s1_r;
            inb_prev_r    <= inb_s2_r;
        end
    end

    // Main map registers
    always_ff @(posedge clk) begin
        if (rst) begin
            analog_lb_r   <= `RST_BYTE;
            far_end_lb_r  <= `RST_BYTE;
            all_ones_r    <= `RST_BYTE;
            absent_mask_r <= `RST_BYTE;
            page_r        <= `RST_PAGE;
        end else begin
            if (wr_alb)  analog_lb_r   <= reg_wdata;
            if (wr_rlb)  far_end_lb_r  <= reg_wdata;
            if (wr_tao)  all_ones_r    <= reg_wdata;
            if (wr_mask) absent_mask_r <= reg_wdata;
            if (wr_page) page_r        <= reg_wdata;
        end
    end

    // Expanded map registers
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                ext_r[i] <= `RST_BYTE;
            end
        end else if (wr_ext) begin
            ext_r[ext_idx] <= reg_wdata;
        end
    end

    // Flags, read data and event levels
    always_ff @(posedge clk) begin
        if (rst) begin
            absent_flag_r <= `RST_CHAN;
            inb_flag_r    <= `RST_CHAN;
            rdata_r       <= `RST_BYTE;
            rvalid_r      <= 1'b0;
            absent_irq_r  <= 1'b0;
            inb_irq_r     <= 1'b0;
        end else begin
            absent_flag_r <= absent_flag_nxt;
            inb_flag_r    <= inb_flag_nxt;
            rvalid_r      <= reg_rd;
            if (reg_rd) rdata_r <= rd_mux;
            absent_irq_r  <= |absent_flag_nxt;
            inb_irq_r     <= |inb_flag_nxt;
        end
    end

    // Outputs
    assign reg_rdata           = rdata_r;
    assign reg_rvalid          = rvalid_r;
    assign analog_loopback_en  = analog_lb_r[3:0];
    assign far_end_loopback_en = far_end_lb_r[3:0];
    assign all_ones_tx_en      = all_ones_r[3:0];
    assign inband_cfg_bit5     = ext_r[`OFS_EXT_INBAND_CFG][`POS_CFG_BIT5];
    assign inband_cfg_bit4     = ext_r[`OFS_EXT_INBAND_CFG][`POS_CFG_BIT4];
    assign inband_cfg_field_a  = ext_r[`OFS_EXT_INBAND_CFG][`POS_CFG_FIELD_A +: 2];
    assign inband_cfg_field_b  = ext_r[`OFS_EXT_INBAND_CFG][`POS_CFG_FIELD_B +: 2];
    assign inband_code_byte_a  = ext_r[`OFS_EXT_CODE_A];
    assign inband_code_byte_b  = ext_r[`OFS_EXT_CODE_B];
    assign signal_absent_irq   = absent_irq_r;
    assign inband_irq          = inb_irq_r;

endmodule
`default_nettype wire

// [rtl/lineif_params.svh]
// Offsets, field positions and reset values of the line interface register bank
`ifndef LINEIF_PARAMS_SVH
`define LINEIF_PARAMS_SVH

`define OFS_REVISION        5'h00
`define OFS_ANALOG_LB       5'h01
`define OFS_FAR_END_LB      5'h02
`define OFS_ALL_ONES_TX     5'h03
`define OFS_ABSENT_STATUS   5'h04
`define OFS_FAULT_STATUS    5'h05
`define OFS_ABSENT_MASK     5'h06
`define OFS_ABSENT_FLAG     5'h08
`define OFS_PAGE_POINTER    5'h1f

`define OFS_EXT_INBAND_CFG  4'h8
`define OFS_EXT_CODE_A      4'h9
`define OFS_EXT_CODE_B      4'ha
`define OFS_EXT_INB_STATUS  4'hb
`define OFS_EXT_INB_MASK    4'hc
`define OFS_EXT_INB_FLAG    4'hd

`define POS_CFG_BIT5        5
`define POS_CFG_BIT4        4
`define POS_CFG_FIELD_A     2
`define POS_CFG_FIELD_B     0

`define RST_BYTE            8'h00
`define RST_CHAN            4'h0
`define RST_PAGE            8'h00

`endif

// [rtl/lineif_pkg.sv]
// Types shared by the line interface register bank
package lineif_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] chan_t;
    typedef logic [4:0] addr_t;
endpackage

// [tb/lineif_regs_sva.sv]
// Concurrent checks of the line interface register bank
`timescale 1ns/1ps
`default_nettype none
module lineif_regs_sva
    import lineif_pkg::*;
#(parameter byte_t REVISION_CODE = 8'hA5) (
    // Clock, reset, host port and code byte b
    input wire logic  clk, rst, reg_wr, reg_rd, reg_rvalid,
    input wire addr_t reg_addr,
    input wire byte_t reg_wdata, reg_rdata, inband_code_byte_b,
    // Controls and events
    input wire chan_t analog_loopback_en, far_end_loopback_en, all_ones_tx_en,
    input wire logic [1:0] inband_cfg_field_a,
    input wire logic  inband_cfg_bit5, signal_absent_irq, inband_irq
);
    byte_t pg_r;
    wire   main_w = reg_wr && pg_r == 8'h00;
    wire   ext_w  = reg_wr && pg_r != 8'h00;
    always_ff @(posedge clk) begin
        pg_r <= rst ? 8'h00 : (reg_wr && reg_addr == 5'h1f) ? reg_wdata : pg_r;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    chk_no_spurious: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read valid");
    chk_id_value: assert property (reg_rd && pg_r == 8'h00 && reg_addr == 5'h00 |=> reg_rdata == REVISION_CODE)
        else $error("revision code wrong");
    chk_alb_write: assert property (main_w && reg_addr == 5'h01 |=> analog_loopback_en == $past(reg_wdata[3:0]))
        else $error("analog loopback not written");
    chk_rlb_write: assert property (main_w && reg_addr == 5'h02 |=> far_end_loopback_en == $past(reg_wdata[3:0]))
        else $error("far end loopback not written");
    chk_tao_write: assert property (main_w && reg_addr == 5'h03 |=> all_ones_tx_en == $past(reg_wdata[3:0]))
        else $error("all ones not written");
    chk_ctrl_hold: assert property (!reg_wr |=> $stable({analog_loopback_en, far_end_loopback_en, all_ones_tx_en}))
        else $error("control changed without write");
    chk_page_read: assert property (reg_rd && !reg_wr && reg_addr == 5'h1f |=> reg_rdata == pg_r)
        else $error("page pointer readback wrong");
    chk_cfg_write: assert property (ext_w && reg_addr == 5'h08 |=>
        {inband_cfg_bit5, inband_cfg_field_a} == $past({reg_wdata[5], reg_wdata[3:2]}))
        else $error("inband config not written");
    chk_code_write: assert property (ext_w && reg_addr == 5'h0a |=> inband_code_byte_b == $past(reg_wdata))
        else $error("code byte not written");
    cover property (main_w && reg_addr == 5'h01);
    cover property ($rose(signal_absent_irq));
    cover property ($rose(inband_irq));
endmodule
`default_nettype wire

// [tb/line_side_model.sv]
// Line side model: per-channel status levels arriving with skew
`timescale 1ns/1ps
`default_nettype none
module line_side_model
    import lineif_pkg::*;
(
    // Requested levels
    input wire chan_t los_req, df_req, inb_req,
    // Levels toward the device, off the clock edge
    output var chan_t los_out, df_out, inb_out
);
    assign #7 los_out = los_req;
    assign #7 df_out = df_req;
    assign #7 inb_out = inb_req;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the line interface register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top import lineif_pkg::*; ;
    localparam byte_t REV = 8'h5c;  // Arbitrary value
    logic  clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, reg_rvalid, sirq, iirq, b5, b4;
    addr_t reg_addr = 5'h00;
    byte_t reg_wdata = 8'h00, reg_rdata, d, ca, qa, qb, v[4];
    chan_t signal_absent_status = 4'h0, df = 4'h0, inb = 4'h0, o, m, sa, fa, ia, analog_loopback_ctrl, far_end_loopback_ctrl, all_ones_tx_ctrl;
    logic [1:0] fla, flb;
    int    err_total = 0, checks_done = 0;
    initial forever #12.5 clk = ~clk;
    line_side_model lm (.los_req(signal_absent_status), .df_req(df), .inb_req(inb), .los_out(sa), .df_out(fa), .inb_out(ia));
    lineif_control_status_regs #(.REVISION_CODE(REV)) dut (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .signal_absent_in(sa), .driver_fault_in(fa), .inband_detect_in(ia),
        .analog_loopback_en(analog_loopback_ctrl), .far_end_loopback_en(far_end_loopback_ctrl), .all_ones_tx_en(all_ones_tx_ctrl),
        .inband_cfg_bit5(b5), .inband_cfg_bit4(b4), .inband_cfg_field_a(fla), .inband_cfg_field_b(flb),
        .inband_code_byte_a(qa), .inband_code_byte_b(qb), .signal_absent_irq(sirq), .inband_irq(iirq));
    function automatic chan_t flag_exp(chan_t old_v, chan_t new_v, chan_t mask);
        return (old_v ^ new_v) & mask;
    endfunction
    task automatic wr(input addr_t a, input byte_t val);
        @(posedge clk);
        #2 reg_wr = 1;
        reg_addr = a;
        reg_wdata = val;
        @(posedge clk);
        #2 reg_wr = 0;
    endtask
    task automatic rc(input addr_t a, input byte_t exp);
        @(posedge clk);
        #2 reg_rd = 1;
        reg_addr = a;
        @(posedge clk);
        #2 reg_rd = 0;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, exp)
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h3b13));
        repeat (8) @(posedge clk);
        #2 rst = 0;
        rc(5'h00, REV);
        for (int i = 1; i < 6; i++) rc(addr_t'(i), 8'h00);
        rc(5'h1f, 8'h00);
        wr(5'h00, 8'hff);
        rc(5'h00, REV);
        for (int i = 1; i < 4; i++) begin
            v[i] = (i == 1) ? 8'h0f : {4'h0, 4'($urandom)};
            wr(addr_t'(i), v[i]);
            rc(addr_t'(i), v[i]);
        end
        `CHK({all_ones_tx_ctrl, far_end_loopback_ctrl, analog_loopback_ctrl}, {v[3][3:0], v[2][3:0], v[1][3:0]})
        o = 4'($urandom) | 4'h1;
        signal_absent_status = o;
        df = 4'($urandom);
        repeat (6) @(posedge clk);
        #2 `CHK(sirq, 1'b0)
        rc(5'h04, {4'h0, o});
        rc(5'h05, {4'h0, df});
        m = 4'($urandom) | 4'h1;
        wr(5'h06, {4'h0, m});
        signal_absent_status = o ^ (4'($urandom) | 4'h1);
        repeat (6) @(posedge clk);
        #2 `CHK(sirq, |flag_exp(o, signal_absent_status, m))
        rc(5'h08, {4'h0, flag_exp(o, signal_absent_status, m)});
        rc(5'h04, {4'h0, signal_absent_status});
        rc(5'h08, 8'h00);
        `CHK(sirq, 1'b0)
        wr(5'h1f, 8'h01);
        rc(5'h1f, 8'h01);
        d = {2'b00, 6'($urandom)};
        wr(5'h08, d);
        rc(5'h08, d);
        `CHK({b5, b4, fla, flb}, d[5:0])
        ca = 8'($urandom);
        wr(5'h09, ca);
        wr(5'h0a, ~ca);
        rc(5'h09, ca);
        rc(5'h0a, ~ca);
        `CHK({qa, qb}, {ca, ~ca})
        wr(5'h0c, 8'h0f);
        inb = 4'h5;
        repeat (6) @(posedge clk);
        #2 `CHK(iirq, 1'b1)
        rc(5'h0d, 8'h05);
        rc(5'h0b, 8'h05);
        rc(5'h0d, 8'h00);
        rc(5'h10, 8'h00);
        wr(5'h1f, 8'h00);
        rc(5'h01, v[1]);
        @(posedge clk);
        #2 rst = 1;
        @(posedge clk);
        #2 rst = 0;
        rc(5'h01, 8'h00);
        rc(5'h1f, 8'h00);
        `CHK({all_ones_tx_ctrl, far_end_loopback_ctrl, analog_loopback_ctrl}, 12'h000)
        complete_run;
    end
    initial begin
        #100000;
        err_total++;
        complete_run;
    end
endmodule
bind lineif_control_status_regs lineif_regs_sva #(.REVISION_CODE(REVISION_CODE)) u_sva (.*);
`default_nettype wire
